// [design/pst_timer.v]
// Period timer with prescaler, postscaler, software gate and APB registers
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "pst_consts.vh"


module pst_timer
#(
	parameter CNT_W  = 8,
	parameter PRE_W  = 3,
	parameter POST_W = 4
)
(
	// Clock and reset
	input  wire        clock_i,
	input  wire        nrst_i,
	// APB slave
	input  wire        psel_i,
	input  wire        penable_i,
	input  wire        pwrite_i,
	input  wire [11:0] paddr_i,
	input  wire [31:0] pwdata_i,
	output reg  [31:0] prdata_o,
	output reg         pready_o,
	output reg         pslverr_o,
	// Pins
	input  wire        timer_clock_input_i,
	input  wire        external_reset_input_i,
	// Events and interrupt
	output reg         postscaled_event_o,
	output reg         irq_o
);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	reg               ctrl_on;
	reg               ctrl_src_ext;
	reg               ctrl_ers_en;
	reg [PRE_W-1:0]   prescale_select;
	reg [POST_W-1:0]  postscale_select;
	reg [CNT_W-1:0]   period_value;
	reg [CNT_W-1:0]   timer_count;
	reg               timer_irq_flag;
	reg               timer_irq_enable;
	reg [1:0]         inst_div;
	reg               inst_tick;
	reg               clk_pin_d;
	reg [1:0]         on_pipe;
	reg [1:0]         ers_pipe;
	reg               on_eff;
	reg               ers_eff;
	reg [(1<<PRE_W)-2:0] pre_cnt;
	reg [POST_W-1:0]  post_cnt;
	reg [31:0]        next_rdata;
	reg               addr_ok;
	wire              clk_pin_lvl;
	wire              ers_lvl;
	wire              ext_tick;
	wire              tmr_tick;
	wire              pre_hit;
	wire              period_match;
	wire              post_hit;
	wire              apb_access;
	wire              apb_write;
	wire              wr_ctrl;
	wire              wr_period;
	wire              wr_status;
	wire              wr_irq_en;

	// ------------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------------
	// Last prescaler count before a pass: ratio 2**sel, zero for 1:1
	function [(1<<PRE_W)-2:0] pre_limit;
		input [PRE_W-1:0] sel;
		reg   [(1<<PRE_W)-1:0] one_hot;
		begin
			one_hot   = {{((1<<PRE_W)-1){1'b0}}, 1'b1} << sel;
			pre_limit = one_hot[(1<<PRE_W)-2:0] - {{((1<<PRE_W)-2){1'b0}}, 1'b1};
		end
	endfunction

	// Register address decode
	function is_reg;
		input [11:0] addr;
		input [11:0] ofs;
		begin
			is_reg = (addr == ofs);
		end
	endfunction

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	pst_sync u_clk_sync
	(
		.clock_i (clock_i),
		.nrst_i  (nrst_i),
		.pin_i   (timer_clock_input_i),
		.level_o (clk_pin_lvl)
	);

	pst_sync u_ers_sync
	(
		.clock_i (clock_i),
		.nrst_i  (nrst_i),
		.pin_i   (external_reset_input_i),
		.level_o (ers_lvl)
	);

	// ------------------------------------------------------------------
	// Timer clock sources
	// ------------------------------------------------------------------
	// Instruction clock enable: one pulse every four system clocks
	always @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			inst_div  <= 2'h0;
			inst_tick <= 1'b0;
		end
		else
		begin
			inst_div  <= inst_div + 2'h1;
			inst_tick <= ({30'h0, inst_div} == (`PST_INST_DIV - 1));
		end
	end

	// Rising edge of the synchronised timer clock pin
	always @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
			clk_pin_d <= 1'b0;
		else
			clk_pin_d <= clk_pin_lvl;
	end

	assign ext_tick = clk_pin_lvl & ~clk_pin_d;
	assign tmr_tick = ctrl_src_ext ? ext_tick : inst_tick;

	// ------------------------------------------------------------------
	// Enable and reset-input delay
	// ------------------------------------------------------------------
	// External source: two full timer clocks; instruction source: one period
	always @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			on_pipe  <= 2'h0;
			ers_pipe <= 2'h0;
			on_eff   <= 1'b0;
			ers_eff  <= 1'b0;
		end
		else if (ctrl_src_ext)
		begin
			if (ext_tick)
			begin
				on_pipe  <= {on_pipe[0], ctrl_on};
				ers_pipe <= {ers_pipe[0], ers_lvl};
				on_eff   <= on_pipe[1];
				ers_eff  <= ers_pipe[1];
			end
		end
		else if (inst_tick)
		begin
			on_pipe  <= {2{ctrl_on}};
			ers_pipe <= {2{ers_lvl}};
			on_eff   <= ctrl_on;
			ers_eff  <= ers_lvl;
		end
	end

	// ------------------------------------------------------------------
	// Prescaler
	// ------------------------------------------------------------------
	assign pre_hit = tmr_tick & on_eff & (pre_cnt >= pre_limit(prescale_select));

	// Counts timer clocks while enabled, passes one in 2**sel
	always @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
			pre_cnt <= {((1<<PRE_W)-1){1'b0}};
		else if (ers_eff & ctrl_ers_en)
			pre_cnt <= {((1<<PRE_W)-1){1'b0}};
		else if (tmr_tick & on_eff)
		begin
			if (pre_hit)
				pre_cnt <= {((1<<PRE_W)-1){1'b0}};
			else
				pre_cnt <= pre_cnt + {{((1<<PRE_W)-2){1'b0}}, 1'b1};
		end
	end

	// ------------------------------------------------------------------
	// Main counter
	// ------------------------------------------------------------------
	assign period_match = pre_hit & (timer_count == period_value);

	// Advances while enabled, wraps to zero after reaching the period
	always @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
			timer_count <= `PST_RST_COUNT;
		else if (ers_eff & ctrl_ers_en)
			timer_count <= {CNT_W{1'b0}};  // Held at zero while reset input high
		else if (pre_hit)
		begin
			if (timer_count == period_value)
				timer_count <= {CNT_W{1'b0}};
			else
				timer_count <= timer_count + {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

	// ------------------------------------------------------------------
	// Postscaler
	// ------------------------------------------------------------------
	assign post_hit = period_match & (post_cnt >= postscale_select);

	// Counts period matches, restarts after each event
	always @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
			post_cnt <= {POST_W{1'b0}};
		else if (ers_eff & ctrl_ers_en)
			post_cnt <= {POST_W{1'b0}};
		else if (period_match)
		begin
			if (post_hit)
				post_cnt <= {POST_W{1'b0}};
			else
				post_cnt <= post_cnt + {{(POST_W-1){1'b0}}, 1'b1};
		end
	end

	// One-cycle postscaled event pulse
	always @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
			postscaled_event_o <= 1'b0;
		else
			postscaled_event_o <= post_hit;
	end

	// ------------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------------
	assign apb_access = psel_i & penable_i & pready_o;
	assign apb_write  = apb_access & pwrite_i & ~pslverr_o;
	assign wr_ctrl    = apb_write & is_reg(paddr_i, `PST_OFS_CTRL);
	assign wr_period  = apb_write & is_reg(paddr_i, `PST_OFS_PERIOD);
	assign wr_status  = apb_write & is_reg(paddr_i, `PST_OFS_STATUS);
	assign wr_irq_en  = apb_write & is_reg(paddr_i, `PST_OFS_IRQ_EN);

	// Read mux and address check
	always @*
	begin
		next_rdata = 32'h00000000;
		addr_ok    = 1'b1;
		case (paddr_i)
			`PST_OFS_CTRL:
			begin
				next_rdata[`PST_CTRL_ON]     = ctrl_on;
				next_rdata[`PST_CTRL_SRC]    = ctrl_src_ext;
				next_rdata[`PST_CTRL_ERS_EN] = ctrl_ers_en;
				next_rdata[`PST_CTRL_PRE_HI:`PST_CTRL_PRE_LO]   = prescale_select;
				next_rdata[`PST_CTRL_POST_HI:`PST_CTRL_POST_LO] = postscale_select;
			end
			`PST_OFS_PERIOD:
				next_rdata[CNT_W-1:0] = period_value;
			`PST_OFS_COUNT:
				next_rdata[CNT_W-1:0] = timer_count;
			`PST_OFS_STATUS:
			begin
				next_rdata[`PST_STAT_IRQ] = timer_irq_flag;
				next_rdata[`PST_STAT_ERS] = ers_eff;
				next_rdata[`PST_STAT_RUN] = on_eff;
			end
			`PST_OFS_IRQ_EN:
				next_rdata[0] = timer_irq_enable;
			default:
				addr_ok = 1'b0;
		endcase
	end

	// One wait state: answer registered in the first access cycle
	always @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h00000000;
		end
		else if (psel_i & penable_i & ~pready_o)
		begin
			pready_o  <= 1'b1;
			pslverr_o <= ~addr_ok;
			prdata_o  <= (pwrite_i | ~addr_ok) ? 32'h00000000 : next_rdata;
		end
		else
		begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Control and period registers
	// ------------------------------------------------------------------
	always @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			ctrl_on          <= 1'b0;
			ctrl_src_ext     <= 1'b0;
			ctrl_ers_en      <= 1'b0;
			prescale_select  <= `PST_RST_PRE;
			postscale_select <= `PST_RST_POST;
			period_value     <= `PST_RST_PERIOD;
			timer_irq_enable <= 1'b0;
		end
		else
		begin
			if (wr_ctrl)
			begin
				ctrl_on          <= pwdata_i[`PST_CTRL_ON];
				ctrl_src_ext     <= pwdata_i[`PST_CTRL_SRC];
				ctrl_ers_en      <= pwdata_i[`PST_CTRL_ERS_EN];
				prescale_select  <= pwdata_i[`PST_CTRL_PRE_HI:`PST_CTRL_PRE_LO];
				postscale_select <= pwdata_i[`PST_CTRL_POST_HI:`PST_CTRL_POST_LO];
			end
			if (wr_period)
				period_value <= pwdata_i[CNT_W-1:0];
			if (wr_irq_en)
				timer_irq_enable <= pwdata_i[0];
		end
	end

	// ------------------------------------------------------------------
	// Interrupt flag and output
	// ------------------------------------------------------------------
	// Sticky flag, set wins over a write-one clear in the same cycle
	always @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
			timer_irq_flag <= 1'b0;
		else if (postscaled_event_o)
			timer_irq_flag <= 1'b1;
		else if (wr_status & pwdata_i[`PST_STAT_IRQ])
			timer_irq_flag <= 1'b0;
	end

	// Level interrupt gated by the enable bit
	always @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
			irq_o <= 1'b0;
		else
			irq_o <= timer_irq_flag & timer_irq_enable;
	end

endmodule // pst_timer

// [pkg/pst_consts.vh]
// Register map, field positions, reset values and timing counts of the period timer
`ifndef PST_CONSTS_VH
`define PST_CONSTS_VH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define PST_OFS_CTRL      12'h000
`define PST_OFS_PERIOD    12'h004
`define PST_OFS_COUNT     12'h008
`define PST_OFS_STATUS    12'h00c
`define PST_OFS_IRQ_EN    12'h010

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define PST_CTRL_ON       0
`define PST_CTRL_SRC      1
`define PST_CTRL_ERS_EN   2
`define PST_CTRL_PRE_LO   4
`define PST_CTRL_PRE_HI   6
`define PST_CTRL_POST_LO  8
`define PST_CTRL_POST_HI  11

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define PST_STAT_IRQ      0
`define PST_STAT_ERS      1
`define PST_STAT_RUN      2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PST_RST_PERIOD    8'hff
`define PST_RST_COUNT     8'h00
`define PST_RST_PRE       3'h0
`define PST_RST_POST      4'h0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PST_SYS_CLK_HZ    40000000
`define PST_INST_DIV      4
`define PST_EXT_SYNC_TICKS 2

`endif

// [design/pst_sync.v]
// Three-stage synchroniser for a pin input with agreement filter
`timescale 1ns/1ps

module pst_sync
(
	// Clock and reset
	input  wire clock_i,
	input  wire nrst_i,
	// Pin side
	input  wire pin_i,
	// Synchronised level
	output reg  level_o
);

	reg meta;
	reg stage2;
	reg stage3;

	// ------------------------------------------------------------------
	// Sampling chain
	// ------------------------------------------------------------------
	// First stage feeds only the second stage
	always @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			meta    <= 1'b0;
			stage2  <= 1'b0;
			stage3  <= 1'b0;
			level_o <= 1'b0;
		end
		else
		begin
			meta   <= pin_i;
			stage2 <= meta;
			stage3 <= stage2;
			if (stage2 == stage3)
				level_o <= stage3; // Change counts once stages two and three agree
		end
	end

endmodule // pst_sync

// [dv/pst_timer_sva.sv]
// Port checker for the period timer
`timescale 1ns/1ps
`include "pst_consts.vh"

module pst_timer_sva
(
	// Clock and reset
	input wire        clock_i,
	input wire        nrst_i,
	// Bus
	input wire        psel_i,
	input wire        penable_i,
	input wire        pwrite_i,
	input wire [11:0] paddr_i,
	input wire        pready_o,
	input wire        pslverr_o,
	// Events
	input wire        postscaled_event_o,
	input wire        irq_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!nrst_i);

	// Completed write that may clear the interrupt
	wire wr_clr = pready_o && pwrite_i
		&& (paddr_i == `PST_OFS_STATUS || paddr_i == `PST_OFS_IRQ_EN);

	AST_READY_WAIT: assert property (psel_i && penable_i && !pready_o |=> pready_o)
		else $error("ready late");
	AST_READY_PULSE: assert property (pready_o |=> !pready_o)
		else $error("ready held");
	AST_READY_IDLE: assert property (!(psel_i && penable_i) |=> !pready_o)
		else $error("ready without access");
	AST_ERR_READY: assert property (pslverr_o |-> pready_o)
		else $error("error without ready");
	AST_ERR_MAP: assert property (pready_o |-> pslverr_o == !(paddr_i inside
		{`PST_OFS_CTRL, `PST_OFS_PERIOD, `PST_OFS_COUNT, `PST_OFS_STATUS, `PST_OFS_IRQ_EN}))
		else $error("error code wrong");
	AST_EVT_PULSE: assert property (postscaled_event_o |=> !postscaled_event_o)
		else $error("event held");
	AST_IRQ_RISE: assert property ($rose(irq_o) |-> $past(postscaled_event_o, 2)
		|| $past(pready_o && pwrite_i && paddr_i == `PST_OFS_IRQ_EN, 2))
		else $error("interrupt without cause");
	AST_IRQ_HOLD: assert property (irq_o && !$past(wr_clr) |=> irq_o)
		else $error("interrupt dropped");
endmodule // pst_timer_sva

bind pst_timer pst_timer_sva pst_timer_sva_inst (.clock_i(clock_i), .nrst_i(nrst_i),
	.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
	.pready_o(pready_o), .pslverr_o(pslverr_o),
	.postscaled_event_o(postscaled_event_o), .irq_o(irq_o));

// [dv/pst_pin_model.sv]
// Far-side model driving the timer clock pin and the reset input pin
`timescale 1ns/1ps

module pst_pin_model
#(
	parameter HALF = 6
)
(
	// Clock and reset
	input  wire clock_i,
	input  wire nrst_i,
	// Control from the bench
	input  wire run_i,
	input  wire rst_lvl_i,
	// Pins
	output reg  tclk_o,
	output reg  ers_o
);
	reg [7:0] ph;

	// Pin clock runs only while asked and stands low otherwise
	always @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			ph <= 8'h00;
			tclk_o <= 1'b0;
			ers_o <= 1'b0;
		end
		else
		begin
			ers_o <= rst_lvl_i;
			if (!run_i || ph == HALF - 1)
				ph <= 8'h00;
			else
				ph <= ph + 8'h01;
			if (!run_i)
				tclk_o <= 1'b0;
			else if (ph == HALF - 1)
				tclk_o <= ~tclk_o;
		end
	end
endmodule // pst_pin_model

// [dv/pst_timer_test.sv]
// Self-checking bench for the period timer
`timescale 1ns/1ps
`include "pst_consts.vh"

module pst_timer_test;
	reg         clock_i, nrst_i, psel_i, penable_i, pwrite_i, pin_run, ers_lvl, erd;
	reg  [11:0] paddr_i;
	reg  [31:0] pwdata_i, rd;
	wire [31:0] prdata_o;
	wire        pready_o, pslverr_o, postscaled_event_o, irq_o, tclk, ers;
	integer     err_count, compares, gap, cnt, evt_n, i, n;

	pst_timer pst_timer_inst (.clock_i(clock_i), .nrst_i(nrst_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.timer_clock_input_i(tclk), .external_reset_input_i(ers),
		.postscaled_event_o(postscaled_event_o), .irq_o(irq_o));
	pst_pin_model #(.HALF(6)) pst_pin_model_inst (.clock_i(clock_i), .nrst_i(nrst_i),
		.run_i(pin_run), .rst_lvl_i(ers_lvl), .tclk_o(tclk), .ers_o(ers));

	initial
	begin
		clock_i = 1'b0;
		forever #12.5 clock_i = ~clock_i;
	end

	// Cycles between the last two events
	always @(posedge clock_i)
	begin
		cnt <= postscaled_event_o ? 1 : cnt + 1;
		if (postscaled_event_o)
		begin
			gap <= cnt;
			evt_n <= evt_n + 1;
		end
	end

	task close_out;
	begin
		$display("mismatches %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	end
	endtask

	task chk(input [31:0] got, input [31:0] exp);
	begin
		compares = compares + 1;
		if (got !== exp)
		begin
			err_count = err_count + 1;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	end
	endtask

	// One bus transfer, held until ready
	task apb(input w, input [11:0] a, input [31:0] d);
	begin
		@(posedge clock_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clock_i);
		penable_i <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clock_i);
			n = n + 1;
		end while (pready_o !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			chk(32'h0, 32'h1);
			close_out;
		end
		rd = prdata_o;
		erd = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	end
	endtask

	task rdc(input [11:0] a, input [31:0] exp);
	begin
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	end
	endtask

	// Wait for k events, then compare the last spacing
	task gap_chk(input integer k, input integer exp);
	begin
		n = 0;
		k = evt_n + k;
		while (evt_n < k && n < 40000)
		begin
			@(posedge clock_i);
			n = n + 1;
		end
		if (n >= 40000)
		begin
			chk(32'h0, 32'h1);
			close_out;
		end
		if (exp > 0)
			chk(gap, exp);
	end
	endtask

	initial
	begin
		{nrst_i, psel_i, penable_i, pwrite_i, pin_run, ers_lvl, erd} = 7'h00;
		paddr_i = 12'h000;
		pwdata_i = 32'h0;
		{err_count, compares, gap, cnt, evt_n} = 0;
		repeat (8) @(posedge clock_i);
		nrst_i <= 1'b1;
		rdc(`PST_OFS_CTRL, 32'h0);
		rdc(`PST_OFS_PERIOD, 32'hff);
		rdc(`PST_OFS_STATUS, 32'h0);
		rdc(`PST_OFS_IRQ_EN, 32'h0);
		apb(1'b0, 12'h014, 32'h0);
		chk(erd, 1);
		apb(1'b1, `PST_OFS_COUNT, 32'h5);
		rdc(`PST_OFS_COUNT, 32'h0);
		apb(1'b1, `PST_OFS_PERIOD, 32'h0);
		for (i = 0; i < 8; i = i + 1)
		begin
			apb(1'b1, `PST_OFS_CTRL, (i << 4) | 1);
			gap_chk(3, 4 << i);
		end
		apb(1'b1, `PST_OFS_PERIOD, 32'h1);
		for (i = 0; i < 16; i = i + 1)
		begin
			apb(1'b1, `PST_OFS_CTRL, (i << 8) | 1);
			gap_chk(3, 8 * (i + 1));
		end
		apb(1'b1, `PST_OFS_PERIOD, 32'h80);
		repeat (40) @(posedge clock_i);
		apb(1'b1, `PST_OFS_CTRL, 32'h0);
		repeat (8) @(posedge clock_i);
		apb(1'b0, `PST_OFS_COUNT, 32'h0);
		repeat (60) @(posedge clock_i);
		rdc(`PST_OFS_COUNT, rd);
		apb(1'b1, `PST_OFS_IRQ_EN, 32'h1);
		apb(1'b1, `PST_OFS_PERIOD, 32'h0);
		apb(1'b1, `PST_OFS_CTRL, 32'h1);
		repeat (4) @(posedge clock_i);
		apb(1'b0, `PST_OFS_STATUS, 32'h0);
		chk(rd[2], 1);
		gap_chk(1, 0);
		for (n = 0; n < 8 && irq_o !== 1'b1; n = n + 1)
			@(posedge clock_i);
		chk(irq_o, 1);
		apb(1'b1, `PST_OFS_CTRL, 32'h0);
		repeat (20) @(posedge clock_i);
		chk(irq_o, 1);
		rdc(`PST_OFS_STATUS, 32'h1);
		apb(1'b1, `PST_OFS_IRQ_EN, 32'h0);
		repeat (4) @(posedge clock_i);
		chk(irq_o, 0);
		apb(1'b1, `PST_OFS_STATUS, 32'h1);
		rdc(`PST_OFS_STATUS, 32'h0);
		apb(1'b1, `PST_OFS_IRQ_EN, 32'h1);
		repeat (4) @(posedge clock_i);
		chk(irq_o, 0);
		pin_run <= 1'b1;
		apb(1'b1, `PST_OFS_CTRL, 32'h3);
		gap_chk(3, 12);
		apb(1'b1, `PST_OFS_PERIOD, 32'h80);
		apb(1'b1, `PST_OFS_CTRL, 32'h7);
		ers_lvl <= 1'b1;
		repeat (60) @(posedge clock_i);
		rdc(`PST_OFS_COUNT, 32'h0);
		apb(1'b0, `PST_OFS_STATUS, 32'h0);
		chk(rd[1], 1);
		chk(rd[2], 1);
		ers_lvl <= 1'b0;
		repeat (80) @(posedge clock_i);
		apb(1'b0, `PST_OFS_COUNT, 32'h0);
		chk(rd[7:0] != 8'h00, 1);
		close_out;
	end
endmodule // pst_timer_test
